// ===== src/dssr_pkg.sv
// Purpose: shared constants and types of the diagnostic status signal router
// Assumes: four status signals, 32-bit route maps, 256 diagnostic numbers
// Notes: parameter port indices and reset values live here only
package dssr_pkg;

    // ----------------------------------------------------------------
    // status signals and map layout
    // ----------------------------------------------------------------
    localparam int NUM_SIG = 4;
    localparam int SIG_FAIL = 0;
    localparam int SIG_CHECK = 1;
    localparam int SIG_OFFSPEC = 2;
    localparam int SIG_MAINT = 3;
    localparam logic [4:0] RANGE_TOP_BIT = 5'h1f;
    localparam int RANGE_LOW_BIT = 16;
    localparam int CFG_TOP_BIT = 15;
    localparam int CFG_LOW_BIT = 1;
    localparam int RSV_BIT = 0;
    localparam int DIAG_AW = 8;

    // ----------------------------------------------------------------
    // parameter port indices
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_FAIL_MAP = 4'h0;
    localparam logic [3:0] IDX_FAIL_PRI = 4'h4;
    localparam logic [3:0] IDX_DET_EN = 4'h8;
    localparam logic [3:0] IDX_SUPPRESS = 4'h9;

    // ----------------------------------------------------------------
    // reset values and priority bands
    // ----------------------------------------------------------------
    localparam logic [NUM_SIG-1:0][31:0] RST_MAP = {
        32'h000f_0000, 32'h00f0_0000, 32'h0f00_0000, 32'hf000_0000};
    localparam logic [31:0] CFG_FIELD_MASK = 32'h0000_fffe;
    localparam logic [31:0] RST_DET_EN = 32'h0000_0000;
    localparam logic [31:0] RST_SUPPRESS = 32'h0000_0000;
    localparam logic [3:0] RST_PRI = 4'h0;
    localparam logic [3:0] PRI_DISPLAY_LO = 4'h1;
    localparam logic [3:0] PRI_XMIT_LO = 4'h2;
    localparam logic [3:0] PRI_XMIT_HI = 4'hf;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic raise;
        logic [DIAG_AW-1:0] diag_id;
        logic [3:0] range_idx;
        logic [3:0] cfg_bit;
    } dssr_evt_t;

    typedef struct packed {
        logic raise;
        logic [DIAG_AW-1:0] diag_id;
        logic [NUM_SIG-1:0] sig;
        logic [NUM_SIG-1:0] disp;
        logic [NUM_SIG-1:0] xmit;
    } dssr_rpt_t;

    // map bit that governs an event: its configurable slot, else its range
    function automatic logic [4:0] dssr_map_bit(input dssr_evt_t e);
        if (e.cfg_bit != 4'h0) begin
            return {1'b0, e.cfg_bit};
        end
        return RANGE_TOP_BIT - {1'b0, e.range_idx};
    endfunction : dssr_map_bit

endpackage : dssr_pkg

// ===== src/dssr_route_mem.sv
// Purpose: per-diagnostic store of the status signals last assigned
// Assumes: one write and one read port, same clock
// Notes: contents undefined after reset; the owner tracks which are live
`timescale 1ns/1ps
module dssr_route_mem #(
    parameter int AW = 8,
    parameter int DW = 4
) (
    // clock
    input wire logic clk_i,
    // write side
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // read side
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // old data on a same-address collision; the owner forwards
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_q[raddr_i];
    end

endmodule : dssr_route_mem

// ===== src/dssr_prio_gate.sv
// Purpose: display and bus-transmit decision for one status signal
// Assumes: priority is a 4-bit field
// Notes: purely combinational; the owner registers the result
`timescale 1ns/1ps
module dssr_prio_gate
    import dssr_pkg::*;
(
    // settings
    input wire logic [3:0] pri_i,
    input wire logic suppress_i,
    // event routing
    input wire logic route_i,
    // decision
    output logic display_o,
    output logic xmit_o
);

    // priority 1 shows locally only; 0 is ignored outright
    assign display_o = route_i && (pri_i >= PRI_DISPLAY_LO);
    // inverted mask: a set bit keeps the event off the bus only
    assign xmit_o = route_i && !suppress_i
                    && (pri_i >= PRI_XMIT_LO) && (pri_i <= PRI_XMIT_HI);

endmodule : dssr_prio_gate

// ===== src/dssr_top.sv
// Purpose: routes diagnostic events onto four status signals with priorities
// Assumes: events and parameter accesses are synchronous to clk_i
// Notes: report follows an event by two cycles; one event per cycle
`timescale 1ns/1ps
module dssr_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // parameter port
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [3:0] cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // block mode
    input wire logic out_of_service_mode_i,
    // diagnostic events
    input wire logic evt_valid_i,
    input wire dssr_pkg::dssr_evt_t evt_i,
    // status reports
    output logic rpt_valid_o,
    output dssr_pkg::dssr_rpt_t rpt_o
);
    import dssr_pkg::*;

    // ----------------------------------------------------------------
    // configuration state
    // ----------------------------------------------------------------
    logic [NUM_SIG-1:0][31:0] map_q;
    logic [NUM_SIG-1:0][3:0] pri_q;
    logic [31:0] det_en_q;
    logic [31:0] suppress_q;
    logic [31:0] rd_d;

    // maps are frozen outside out-of-service mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            map_q <= RST_MAP;
        end else if (cfg_wr_i && out_of_service_mode_i) begin
            for (int s = 0; s < NUM_SIG; s++) begin
                if (cfg_addr_i == IDX_FAIL_MAP + 4'(s)) begin
                    map_q[s] <= {cfg_wdata_i[31:1], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pri_q <= {NUM_SIG{RST_PRI}};
        end else if (cfg_wr_i) begin
            for (int s = 0; s < NUM_SIG; s++) begin
                if (cfg_addr_i == IDX_FAIL_PRI + 4'(s)) begin
                    pri_q[s] <= cfg_wdata_i[3:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            det_en_q <= RST_DET_EN;
            suppress_q <= RST_SUPPRESS;
        end else if (cfg_wr_i) begin
            if (cfg_addr_i == IDX_DET_EN) begin
                det_en_q <= cfg_wdata_i & CFG_FIELD_MASK;
            end
            if (cfg_addr_i == IDX_SUPPRESS) begin
                suppress_q <= cfg_wdata_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // parameter readback
    // ----------------------------------------------------------------
    always_comb begin
        rd_d = 32'h0000_0000;
        for (int s = 0; s < NUM_SIG; s++) begin
            if (cfg_addr_i == IDX_FAIL_MAP + 4'(s)) begin
                rd_d = map_q[s];
            end
            if (cfg_addr_i == IDX_FAIL_PRI + 4'(s)) begin
                rd_d = {28'h000_0000, pri_q[s]};
            end
        end
        if (cfg_addr_i == IDX_DET_EN) begin
            rd_d = det_en_q;
        end
        if (cfg_addr_i == IDX_SUPPRESS) begin
            rd_d = suppress_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_rvalid_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            cfg_rdata_o <= cfg_rd_i ? rd_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // event pipeline
    // ----------------------------------------------------------------
    logic s1_v_q;
    dssr_evt_t s1_evt_q;
    logic fwd_q;
    logic [NUM_SIG-1:0] fwd_route_q;
    logic [NUM_SIG-1:0] mem_rdata;
    logic [NUM_SIG-1:0] stored;
    logic [NUM_SIG-1:0] fresh;
    logic [NUM_SIG-1:0] route_d;
    logic [NUM_SIG-1:0] disp_d;
    logic [NUM_SIG-1:0] xmit_d;
    logic [2**DIAG_AW-1:0] active_q;
    logic was_active;
    logic [4:0] s1_bit;
    logic supp;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_v_q <= 1'b0;
            s1_evt_q <= '0;
        end else begin
            s1_v_q <= evt_valid_i;
            s1_evt_q <= evt_i;
        end
    end

    // the memory cannot see a write made in the same cycle as the read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_q <= 1'b0;
            fwd_route_q <= '0;
        end else begin
            fwd_q <= s1_v_q && (s1_evt_q.diag_id == evt_i.diag_id);
            fwd_route_q <= route_d;
        end
    end

    dssr_route_mem #(
        .AW(DIAG_AW),
        .DW(NUM_SIG)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(s1_v_q),
        .waddr_i(s1_evt_q.diag_id),
        .wdata_i(route_d),
        .raddr_i(evt_i.diag_id),
        .rdata_o(mem_rdata)
    );

    assign stored = fwd_q ? fwd_route_q : mem_rdata;
    assign was_active = active_q[s1_evt_q.diag_id];
    assign s1_bit = dssr_map_bit(s1_evt_q);
    assign supp = suppress_q[s1_bit];

    always_comb begin
        for (int s = 0; s < NUM_SIG; s++) begin
            fresh[s] = map_q[s][s1_bit];
        end
        if (s1_evt_q.cfg_bit != 4'h0 && !det_en_q[s1_evt_q.cfg_bit]) begin
            fresh = '0;
        end
        if (was_active) begin
            route_d = stored;
        end else if (s1_evt_q.raise) begin
            route_d = fresh;
        end else begin
            route_d = '0;
        end
    end

    for (genvar g = 0; g < NUM_SIG; g++) begin : g_gate
        dssr_prio_gate u_gate (
            .pri_i(pri_q[g]),
            .suppress_i(supp),
            .route_i(route_d[g]),
            .display_o(disp_d[g]),
            .xmit_o(xmit_d[g])
        );
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_q <= '0;
        end else if (s1_v_q) begin
            active_q[s1_evt_q.diag_id] <= s1_evt_q.raise;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rpt_valid_o <= 1'b0;
            rpt_o <= '0;
        end else begin
            rpt_valid_o <= s1_v_q;
            if (s1_v_q) begin
                rpt_o <= '{raise: s1_evt_q.raise, diag_id: s1_evt_q.diag_id,
                           sig: route_d, disp: disp_d, xmit: xmit_d};
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic fresh_chk;
    // slot events only count when their slot is detection enabled
    assign fresh_chk = map_q[SIG_CHECK][s1_bit]
                       && (s1_evt_q.cfg_bit == 4'h0 || det_en_q[s1_evt_q.cfg_bit]);

    property p_rsv_zero;
        @(posedge clk_i) disable iff (rst_i)
        cfg_rvalid_o && $past(cfg_addr_i) < IDX_FAIL_PRI |-> cfg_rdata_o[RSV_BIT] == 1'b0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved map bit set");

    property p_cfg_rst;
        @(posedge clk_i)
        $fell(rst_i) |-> map_q[SIG_FAIL] == 32'hf000_0000 && map_q[SIG_MAINT][15:1] == 15'h0;
    endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("map reset value wrong");

    property p_range_route;
        @(posedge clk_i) disable iff (rst_i)
        s1_v_q && s1_evt_q.raise && !was_active |=> rpt_o.sig[SIG_CHECK] == $past(fresh_chk);
    endproperty
    a_range_route: assert property (p_range_route) else $error("range not routed");

    property p_no_route;
        @(posedge clk_i) disable iff (rst_i)
        rpt_valid_o && rpt_o.sig == 4'h0 |-> rpt_o.xmit == 4'h0 && rpt_o.disp == 4'h0;
    endproperty
    a_no_route: assert property (p_no_route) else $error("unrouted event reported");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        s1_v_q && was_active |=> rpt_o.sig == $past(stored);
    endproperty
    a_hold: assert property (p_hold) else $error("active route changed");

    property p_xmit_pri;
        @(posedge clk_i) disable iff (rst_i)
        rpt_valid_o && rpt_o.xmit[SIG_OFFSPEC] |-> $past(pri_q[SIG_OFFSPEC]) >= PRI_XMIT_LO;
    endproperty
    a_xmit_pri: assert property (p_xmit_pri) else $error("transmit below priority 2");

    property p_pri_one;
        @(posedge clk_i) disable iff (rst_i)
        rpt_valid_o && $past(pri_q[SIG_CHECK]) == 4'h1
        |-> !rpt_o.xmit[SIG_CHECK] && rpt_o.disp[SIG_CHECK] == rpt_o.sig[SIG_CHECK];
    endproperty
    a_pri_one: assert property (p_pri_one) else $error("priority 1 misused");

    property p_pri_zero;
        @(posedge clk_i) disable iff (rst_i)
        rpt_valid_o && $past(pri_q[SIG_FAIL]) == 4'h0
        |-> !rpt_o.disp[SIG_FAIL] && !rpt_o.xmit[SIG_FAIL];
    endproperty
    a_pri_zero: assert property (p_pri_zero) else $error("priority 0 not ignored");

    property p_suppress;
        @(posedge clk_i) disable iff (rst_i)
        s1_v_q && supp |=> rpt_o.xmit == 4'h0;
    endproperty
    a_suppress: assert property (p_suppress) else $error("suppressed event sent");

    property p_detect;
        @(posedge clk_i) disable iff (rst_i)
        s1_v_q && !was_active && s1_evt_q.cfg_bit != 4'h0 && !det_en_q[s1_evt_q.cfg_bit]
        |=> rpt_o.sig == 4'h0;
    endproperty
    a_detect: assert property (p_detect) else $error("undetected slot recorded");

    property p_latency;
        @(posedge clk_i) disable iff (rst_i)
        evt_valid_i |-> ##2 rpt_valid_o;
    endproperty
    a_latency: assert property (p_latency) else $error("report latency not 2");

endmodule : dssr_top

// ===== verification/dssr_host_model.sv
// Purpose: host model that sets the router parameters
// Assumes: drives on the falling edge of clk_i
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/1ps
module dssr_host_model (
    // clock
    input wire logic clk_i,
    // parameter port
    output logic cfg_wr_o,
    output logic cfg_rd_o,
    output logic [3:0] cfg_addr_o,
    output logic [31:0] cfg_wdata_o,
    input wire logic [31:0] cfg_rdata_i,
    input wire logic cfg_rvalid_i,
    // block mode
    output logic out_of_service_mode_o
);
    initial begin
        cfg_wr_o = 1'b0;
        cfg_rd_o = 1'b0;
        cfg_addr_o = 4'h0;
        cfg_wdata_o = 32'h0;
        out_of_service_mode_o = 1'b0;
    end

    // raw write, no mode handling; used to provoke a refusal
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(negedge clk_i);
        cfg_wr_o = 1'b1;
        cfg_addr_o = a;
        cfg_wdata_o = d;
        @(negedge clk_i);
        cfg_wr_o = 1'b0;
        cfg_addr_o = ~a;
        cfg_wdata_o = ~d;
    endtask : wr

    task automatic map_wr(input logic [3:0] a, input logic [31:0] d);
        @(negedge clk_i);
        out_of_service_mode_o = 1'b1;
        wr(a, d);
        out_of_service_mode_o = 1'b0;
    endtask : map_wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic v);
        @(negedge clk_i);
        cfg_rd_o = 1'b1;
        cfg_addr_o = a;
        @(negedge clk_i);
        d = cfg_rdata_i;
        v = cfg_rvalid_i;
        cfg_rd_o = 1'b0;
        cfg_addr_o = ~a;
    endtask : rd
endmodule : dssr_host_model

// ===== verification/tb_dssr_top.sv
// Purpose: self-checking bench of the status signal router
// Assumes: inputs change on the falling edge
// Notes: each diagnostic id raised once unless a test reuses it on purpose
`timescale 1ns/1ps
module tb_dssr_top;
    import dssr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cfg_wr, cfg_rd, cfg_rvalid, out_of_service_mode, evt_valid_i, rpt_valid_o;
    logic [3:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, sup_m;
    logic [3:0] pri_m [4];
    dssr_evt_t evt_i;
    dssr_rpt_t rpt_o;
    int error_cnt = 0;
    int n_tests = 0;

    always #5 clk_i = ~clk_i;

    dssr_host_model i_dssr_host_model (.clk_i(clk_i), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd),
        .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata),
        .cfg_rvalid_i(cfg_rvalid), .out_of_service_mode_o(out_of_service_mode));

    dssr_top i_dssr_top (.clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
        .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
        .cfg_rvalid_o(cfg_rvalid), .out_of_service_mode_i(out_of_service_mode),
        .evt_valid_i(evt_valid_i), .evt_i(evt_i), .rpt_valid_o(rpt_valid_o), .rpt_o(rpt_o));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic v;
        i_dssr_host_model.rd(a, d, v);
        chk(32'(v), 32'h1);
        chk(d, exp);
        // answer stands one cycle, then read data fall back to zero
        @(negedge clk_i);
        chk(32'(cfg_rvalid), 32'h0);
        chk(cfg_rdata, 32'h0);
    endtask : rdchk

    // expected report worked out from the tb copies of priority and mask
    function automatic dssr_rpt_t exp_rpt(input logic r, input logic [7:0] id,
                                          input logic [3:0] rg, input logic [3:0] cb,
                                          input logic [3:0] sg);
        dssr_rpt_t e;
        logic [4:0] b;
        b = (cb != 4'h0) ? {1'b0, cb} : 5'h1f - {1'b0, rg};
        e.raise = r;
        e.diag_id = id;
        e.sig = sg;
        for (int s = 0; s < 4; s++) begin
            e.disp[s] = sg[s] && (pri_m[s] >= 4'h1);
            e.xmit[s] = sg[s] && (pri_m[s] >= 4'h2) && !sup_m[b];
        end
        return e;
    endfunction : exp_rpt

    task automatic ev(input logic r, input logic [7:0] id, input logic [3:0] rg,
                      input logic [3:0] cb, input logic [3:0] sg);
        dssr_rpt_t e;
        e = exp_rpt(r, id, rg, cb, sg);
        @(negedge clk_i);
        evt_valid_i = 1'b1;
        evt_i = '{r, id, rg, cb};
        @(negedge clk_i);
        evt_valid_i = 1'b0;
        @(negedge clk_i);
        chk(32'(rpt_valid_o), 32'h1);
        chk(32'(rpt_o), 32'(e));
        // valid is a single pulse, the report itself stands
        @(negedge clk_i);
        chk(32'(rpt_valid_o), 32'h0);
        chk(32'(rpt_o), 32'(e));
    endtask : ev

    task automatic t_reset();
        for (int s = 0; s < 4; s++) begin
            rdchk(4'(s), 32'hf000_0000 >> (4 * s));
            rdchk(4'(s + 4), 32'h0);
        end
        rdchk(4'h8, 32'h0);
        rdchk(4'h9, 32'h0);
        rdchk(4'hf, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_maps();
        i_dssr_host_model.wr(4'h0, 32'h0);
        rdchk(4'h0, 32'hf000_0000);
        i_dssr_host_model.map_wr(4'h0, 32'hffff_ffff);
        rdchk(4'h0, 32'hffff_fffe);
        i_dssr_host_model.map_wr(4'h0, 32'hf000_0000);
        i_dssr_host_model.wr(4'h8, 32'hffff_ffff);
        rdchk(4'h8, 32'h0000_fffe);
        i_dssr_host_model.wr(4'h8, 32'h0);
        $display("test maps done");
    endtask : t_maps

    task automatic t_prio();
        pri_m = '{4'h0, 4'h1, 4'h2, 4'hf};
        for (int s = 0; s < 4; s++) begin
            i_dssr_host_model.wr(4'(s + 4), {28'hfffffff, pri_m[s]});
            rdchk(4'(s + 4), {28'h0, pri_m[s]});
        end
        for (int r = 0; r < 16; r++) begin
            ev(1'b1, 8'(r), 4'(r), 4'h0, 4'h1 << (r / 4));
        end
        $display("test priority done");
    endtask : t_prio

    task automatic t_remap();
        i_dssr_host_model.map_wr(4'h0, 32'h3000_0000);
        i_dssr_host_model.map_wr(4'h1, 32'h4f00_0000);
        ev(1'b1, 8'h14, 4'h1, 4'h0, 4'h2);
        ev(1'b1, 8'h15, 4'h1, 4'h0, 4'h2);
        ev(1'b1, 8'h16, 4'h0, 4'h0, 4'h0);
        ev(1'b1, 8'h01, 4'h1, 4'h0, 4'h1);
        ev(1'b0, 8'h01, 4'h1, 4'h0, 4'h1);
        ev(1'b1, 8'h01, 4'h1, 4'h0, 4'h2);
        $display("test remap done");
    endtask : t_remap

    task automatic t_slot();
        ev(1'b1, 8'h1e, 4'h4, 4'h5, 4'h0);
        i_dssr_host_model.wr(4'h8, 32'h0000_0020);
        i_dssr_host_model.map_wr(4'h2, 32'h00f0_0020);
        ev(1'b1, 8'h1f, 4'h4, 4'h5, 4'h4);
        i_dssr_host_model.wr(4'h9, 32'h0000_0020);
        sup_m = 32'h0000_0020;
        ev(1'b1, 8'h20, 4'h4, 4'h5, 4'h4);
        ev(1'b1, 8'h21, 4'h4, 4'h0, 4'h2);
        $display("test slot done");
    endtask : t_slot

    // raise then clear of one id on consecutive cycles: the clear must see the raise's route
    task automatic t_b2b();
        dssr_rpt_t e1;
        dssr_rpt_t e2;
        e1 = exp_rpt(1'b1, 8'h30, 4'h5, 4'h0, 4'h2);
        e2 = exp_rpt(1'b0, 8'h30, 4'h5, 4'h0, 4'h2);
        @(negedge clk_i);
        evt_valid_i = 1'b1;
        evt_i = '{1'b1, 8'h30, 4'h5, 4'h0};
        @(negedge clk_i);
        evt_i = '{1'b0, 8'h30, 4'h5, 4'h0};
        @(negedge clk_i);
        evt_valid_i = 1'b0;
        chk(32'(rpt_valid_o), 32'h1);
        chk(32'(rpt_o), 32'(e1));
        @(negedge clk_i);
        chk(32'(rpt_valid_o), 32'h1);
        chk(32'(rpt_o), 32'(e2));
        $display("test back to back done");
    endtask : t_b2b

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // whole run needs about 200 cycles
    initial begin
        #100000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        evt_valid_i = 1'b0;
        evt_i = '0;
        sup_m = 32'h0;
        pri_m = '{4'h0, 4'h0, 4'h0, 4'h0};
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_maps();
        t_prio();
        t_remap();
        t_slot();
        t_b2b();
        final_report();
    end
endmodule : tb_dssr_top
